// ### include/calib_pkg.sv
// package with command, mode register and timing constants of the calibration block
package calib_pkg;

    // ************************************************************
    // command encoding (cs_n, ras_n, cas_n, we_n)
    // ************************************************************
    localparam logic [3:0] CMD_MODE_SET = 4'h0;
    localparam logic [3:0] CMD_READ     = 4'h5;
    localparam logic [3:0] CMD_WRITE    = 4'h4;
    localparam logic [3:0] CMD_NOP      = 4'h7;

    // ************************************************************
    // mode register selection and field positions
    // ************************************************************
    localparam logic [2:0] MODE_REG_ZERO  = 3'h0;
    localparam logic [2:0] MODE_REG_ONE   = 3'h1;
    localparam logic [2:0] MODE_REG_THREE = 3'h3;
    localparam int         WL_ENABLE_BIT  = 7;
    localparam int         PATTERN_EN_BIT = 2;
    localparam int         LOC_LSB        = 0;
    localparam int         ORDER_BIT      = 2;
    localparam int         CHOP_SEL_BIT   = 12;
    localparam int         BL_LSB         = 0;
    localparam logic [1:0] BL_FIXED8      = 2'h0;
    localparam logic [1:0] BL_ON_FLY      = 2'h1;
    localparam logic [1:0] BL_FIXED4      = 2'h2;
    localparam int         AUTOCLOSE_BIT  = 10;

    // ************************************************************
    // pattern contents and reset values
    // ************************************************************
    localparam logic [1:0] LOC_CALIB       = 2'h0;
    localparam logic [7:0] CALIB_PATTERN   = 8'hAA;
    localparam logic [7:0] RESERVED_PATTERN = 8'h00;
    localparam logic [4:0] READ_LAT_RESET  = 5'h06;

    // ************************************************************
    // timing: tMOD / tMRD in clock cycles of the memory clock
    // ************************************************************
    localparam int TMRD_CYC = 4;
    localparam int TMOD_CYC = 12;
    localparam int BURST8_BEATS = 8;
    localparam int BURST4_BEATS = 4;
    localparam int LAT_DEPTH = 32;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [2:0]  bank;
        logic [13:0] addr;
    } command_type;

    typedef struct packed {
        logic [7:0] pattern;
        logic       chop;
        logic       upper;
    } burst_req_type;

endpackage : calib_pkg

// ### logic/calib_modes.sv
// calibration-mode logic: write leveling feedback/exit and pattern readout
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module calib_modes
(
    input  wire logic                   CLK_SYS_IN,
    input  wire logic                   RST_N_IN,
    input  wire calib_pkg::command_type CMD_IN,
    input  wire logic [4:0]             READ_LAT_IN,
    input  wire logic                   STROBE_RISE_IN,
    input  wire logic                   CK_SAMPLE_IN,
    input  wire logic                   ALL_BIT_FEEDBACK_IN,
    output logic      [7:0]             DQ_OUT,
    output logic      [7:0]             DQ_OE_OUT,
    output logic                        LEVELING_OUT,
    output logic                        PATTERN_MODE_OUT,
    output logic                        CMD_READY_OUT,
    output logic                        MODE_SET_READY_OUT,
    output logic                        ARRAY_READ_OUT,
    output logic                        PRECHARGE_OUT
);

    // ************************************************************
    // mode register decode
    // ************************************************************
    logic        is_mode_set;
    logic        is_read;
    logic        leveling_r;
    logic        pattern_en_r;
    logic [1:0]  location_r;
    logic [1:0]  burst_mode_r;
    logic [7:0]  fb_r;

    assign is_mode_set = (CMD_IN.cmd == calib_pkg::CMD_MODE_SET);
    assign is_read     = (CMD_IN.cmd == calib_pkg::CMD_READ);

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        // async reset clears pattern mode too, even while enabled
        if (!RST_N_IN)
        begin
            leveling_r   <= 1'b0;
            pattern_en_r <= 1'b0;
            location_r   <= calib_pkg::LOC_CALIB;
            burst_mode_r <= calib_pkg::BL_FIXED8;
        end
        else if (is_mode_set)
        begin
            unique case (CMD_IN.bank)
                calib_pkg::MODE_REG_ZERO:
                    burst_mode_r <= CMD_IN.addr[calib_pkg::BL_LSB +: 2];
                calib_pkg::MODE_REG_ONE:
                    leveling_r <= CMD_IN.addr[calib_pkg::WL_ENABLE_BIT];
                calib_pkg::MODE_REG_THREE:
                begin
                    pattern_en_r <= CMD_IN.addr[calib_pkg::PATTERN_EN_BIT];
                    location_r   <= CMD_IN.addr[calib_pkg::LOC_LSB +: 2];
                end
                default:
                    ;
            endcase
        end
    end

    // ************************************************************
    // command spacing after a mode-set
    // ************************************************************
    logic [3:0] mod_cnt_r;
    logic [3:0] mrd_cnt_r;

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            mod_cnt_r <= 4'h0;
            mrd_cnt_r <= 4'h0;
        end
        else if (is_mode_set)
        begin
            mod_cnt_r <= 4'(calib_pkg::TMOD_CYC - 1);
            mrd_cnt_r <= 4'(calib_pkg::TMRD_CYC - 1);
        end
        else
        begin
            if (mod_cnt_r != 4'h0)
                mod_cnt_r <= mod_cnt_r - 4'h1;
            if (mrd_cnt_r != 4'h0)
                mrd_cnt_r <= mrd_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            CMD_READY_OUT      <= 1'b1;
            MODE_SET_READY_OUT <= 1'b1;
        end
        else
        begin
            CMD_READY_OUT      <= !is_mode_set && (mod_cnt_r <= 4'h1);
            MODE_SET_READY_OUT <= !is_mode_set && (mrd_cnt_r <= 4'h1);
        end
    end

    // ************************************************************
    // read latency pipeline for pattern bursts
    // ************************************************************
    // burst request is shifted by the same read latency as array reads
    calib_pkg::burst_req_type                       req_now;
    logic [calib_pkg::LAT_DEPTH-1:0]                lat_valid_r;
    calib_pkg::burst_req_type [calib_pkg::LAT_DEPTH-1:0] lat_req_r;
    logic                                           chop;
    logic                                           pattern_read;

    always_comb
    begin
        unique case (burst_mode_r)
            calib_pkg::BL_ON_FLY: chop = !CMD_IN.addr[calib_pkg::CHOP_SEL_BIT];
            calib_pkg::BL_FIXED4: chop = 1'b1;
            default:              chop = 1'b0;
        endcase
    end

    assign pattern_read = is_read && pattern_en_r;

    always_comb
    begin
        req_now.pattern = (location_r == calib_pkg::LOC_CALIB) ?
                          calib_pkg::CALIB_PATTERN : calib_pkg::RESERVED_PATTERN;
        req_now.chop    = chop;
        // eight-beat bursts always start at beat 0; ignore A2 there
        req_now.upper   = chop && CMD_IN.addr[calib_pkg::ORDER_BIT];
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            lat_valid_r <= '0;
            lat_req_r   <= '0;
        end
        else
        begin
            lat_valid_r <= {lat_valid_r[calib_pkg::LAT_DEPTH-2:0], pattern_read};
            lat_req_r   <= {lat_req_r[calib_pkg::LAT_DEPTH-2:0], req_now};
        end
    end

    // ************************************************************
    // burst engine on the data bits
    // ************************************************************
    logic [4:0] lat_sel;
    logic       burst_start;
    calib_pkg::burst_req_type start_req;
    calib_pkg::burst_req_type cur_r;
    logic [3:0] beat_r;
    logic [3:0] beats_left_r;

    // latency of at least two cycles; tap 0 is one cycle after the command
    assign lat_sel     = (READ_LAT_IN < 5'h02) ? 5'h00 : READ_LAT_IN - 5'h02;
    assign burst_start = lat_valid_r[lat_sel];
    assign start_req   = lat_req_r[lat_sel];

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            cur_r        <= '0;
            beat_r       <= 4'h0;
            beats_left_r <= 4'h0;
        end
        else if (burst_start)
        begin
            // a new burst takes over; back-to-back reads run seamless
            cur_r        <= start_req;
            beat_r       <= start_req.upper ? 4'h4 : 4'h0;
            beats_left_r <= start_req.chop ? 4'(calib_pkg::BURST4_BEATS) :
                                             4'(calib_pkg::BURST8_BEATS);
        end
        else if (beats_left_r != 4'h0)
        begin
            beat_r       <= beat_r + 4'h1;
            beats_left_r <= beats_left_r - 4'h1;
        end
    end

    // ************************************************************
    // leveling feedback capture
    // ************************************************************
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            fb_r <= 8'h00;
        else if (!leveling_r)
            fb_r <= 8'h00;
        else if (STROBE_RISE_IN)
            fb_r <= ALL_BIT_FEEDBACK_IN ? {8{CK_SAMPLE_IN}} : {7'h00, CK_SAMPLE_IN};
    end

    // ************************************************************
    // data pin outputs
    // ************************************************************
    logic pattern_bit;

    assign pattern_bit = cur_r.pattern[beat_r[2:0]];

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            DQ_OUT    <= 8'h00;
            DQ_OE_OUT <= 8'h00;
        end
        else if (beats_left_r != 4'h0)
        begin
            DQ_OUT    <= {8{pattern_bit}};
            DQ_OE_OUT <= 8'hFF;
        end
        else if (leveling_r)
        begin
            // unused bits stay low during leveling unless ALL_BIT_FEEDBACK_IN copies the sample onto all eight bits
            DQ_OUT    <= fb_r;
            DQ_OE_OUT <= 8'hFF;
        end
        else
        begin
            DQ_OUT    <= 8'h00;
            DQ_OE_OUT <= 8'h00;
        end
    end

    // ************************************************************
    // status and array steering
    // ************************************************************
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            LEVELING_OUT     <= 1'b0;
            PATTERN_MODE_OUT <= 1'b0;
            ARRAY_READ_OUT   <= 1'b0;
            PRECHARGE_OUT    <= 1'b0;
        end
        else
        begin
            LEVELING_OUT     <= leveling_r;
            PATTERN_MODE_OUT <= pattern_en_r;
            ARRAY_READ_OUT   <= is_read && !pattern_en_r;
            // autoclose suppressed while pattern readout is on
            PRECHARGE_OUT    <= is_read && !pattern_en_r &&
                                CMD_IN.addr[calib_pkg::AUTOCLOSE_BIT];
        end
    end

endmodule : calib_modes

`default_nettype wire

// ### test/calib_modes_chk.sv
// assertion checker of the calibration-mode block
`timescale 1ns/100ps
`default_nettype none
module calib_modes_chk
(
    input wire logic                   CLK_SYS_IN,
    input wire logic                   RST_N_IN,
    input wire calib_pkg::command_type CMD_IN,
    input wire logic [4:0]             READ_LAT_IN,
    input wire logic                   STROBE_RISE_IN,
    input wire logic                   CK_SAMPLE_IN,
    input wire logic                   ALL_BIT_FEEDBACK_IN,
    input wire logic [7:0]             DQ_OUT,
    input wire logic [7:0]             DQ_OE_OUT,
    input wire logic                   LEVELING_OUT,
    input wire logic                   PATTERN_MODE_OUT,
    input wire logic                   CMD_READY_OUT,
    input wire logic                   MODE_SET_READY_OUT,
    input wire logic                   ARRAY_READ_OUT,
    input wire logic                   PRECHARGE_OUT
);
    // ****************************************
    // helper counters and properties
    // ****************************************
    logic [4:0] since_r;
    logic [5:0] lat_r;
    wire logic  ms = CMD_IN.cmd == calib_pkg::CMD_MODE_SET;
    wire logic  rd = CMD_IN.cmd == calib_pkg::CMD_READ && PATTERN_MODE_OUT;
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    // both saturate so an old command never re-arms a check
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            since_r <= 5'h0D;
            lat_r <= 6'h00;
        end
        else
        begin
            since_r <= ms ? 5'h01 : since_r + 5'(since_r < 5'h0D);
            lat_r <= rd ? 6'h01 : lat_r + 6'(lat_r != 6'h00 && lat_r < 6'h3F);
        end
    end
    cmd_wait_a: assert property (CMD_READY_OUT == (int'(since_r) >= calib_pkg::TMOD_CYC))
        else $error("command ready wrong");
    mset_wait_a: assert property (MODE_SET_READY_OUT == (int'(since_r) >= calib_pkg::TMRD_CYC))
        else $error("mode-set ready wrong");
    level_set_a: assert property (ms && CMD_IN.bank == 3'h1 |-> ##2 LEVELING_OUT == $past(CMD_IN.addr[7], 2))
        else $error("leveling flag wrong");
    pat_set_a: assert property (ms && CMD_IN.bank == 3'h3 |-> ##2 PATTERN_MODE_OUT == $past(CMD_IN.addr[2], 2))
        else $error("pattern flag wrong");
    prime_low_a: assert property (LEVELING_OUT && !ALL_BIT_FEEDBACK_IN |-> DQ_OUT[7:1] == 7'h00)
        else $error("idle data bits not low");
    fb_echo_a: assert property (STROBE_RISE_IN && LEVELING_OUT |-> ##2 DQ_OUT[0] == $past(CK_SAMPLE_IN, 2))
        else $error("feedback wrong");
    redirect_a: assert property (rd |=> !ARRAY_READ_OUT && !PRECHARGE_OUT)
        else $error("pattern read reached array");
    latency_a: assert property (lat_r == {1'b0, READ_LAT_IN} + 6'h01 |-> DQ_OE_OUT == 8'hFF)
        else $error("pattern burst late");
    cover property (rd);
    cover property (STROBE_RISE_IN && LEVELING_OUT);
    cover property (ms && CMD_IN.bank == 3'h3);
endmodule : calib_modes_chk
bind calib_modes calib_modes_chk u_chk
(
    .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .CMD_IN(CMD_IN),
    .READ_LAT_IN(READ_LAT_IN), .STROBE_RISE_IN(STROBE_RISE_IN),
    .CK_SAMPLE_IN(CK_SAMPLE_IN), .ALL_BIT_FEEDBACK_IN(ALL_BIT_FEEDBACK_IN),
    .DQ_OUT(DQ_OUT), .DQ_OE_OUT(DQ_OE_OUT), .LEVELING_OUT(LEVELING_OUT),
    .PATTERN_MODE_OUT(PATTERN_MODE_OUT), .CMD_READY_OUT(CMD_READY_OUT),
    .MODE_SET_READY_OUT(MODE_SET_READY_OUT), .ARRAY_READ_OUT(ARRAY_READ_OUT),
    .PRECHARGE_OUT(PRECHARGE_OUT)
);
`default_nettype wire

// ### test/ctl_model.sv
// controller model that sends commands and leveling strobes
`timescale 1ns/100ps
`default_nettype none
module ctl_model
(
    input  wire logic                  clk_in,
    output var calib_pkg::command_type cmd_out,
    output var logic                   strobe_out,
    output var logic                   ck_out
);
    // ****************************************
    // command and strobe tasks
    // ****************************************
    // banks never opened, loop taken as locked, no write ever sent
    // termination pin not modelled, taken as held low at exit
    initial
    begin
        cmd_out = '{cmd: calib_pkg::CMD_NOP, bank: 3'h0, addr: 14'h0000};
        strobe_out = 1'b0;
        ck_out = 1'b0;
    end
    task automatic issue(input logic [2:0] b, input logic [13:0] a, input logic [3:0] c);
        @(posedge clk_in);
        cmd_out <= '{cmd: c, bank: b, addr: a};
        @(posedge clk_in);
        // lines do not keep the last address between commands
        cmd_out <= '{cmd: calib_pkg::CMD_NOP, bank: ~b, addr: ~a};
    endtask : issue
    task automatic pulse(input logic c);
        @(posedge clk_in);
        strobe_out <= 1'b1;
        ck_out <= c;
        @(posedge clk_in);
        strobe_out <= 1'b0;
        ck_out <= ~c;
    endtask : pulse
endmodule : ctl_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking testbench of the calibration-mode block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int RL = 6;
    logic                   clk, rst_n, all_bit, strobe, ck_smp;
    logic [4:0]             read_lat;
    calib_pkg::command_type cmd;
    logic [7:0]             dq, dq_oe;
    logic                   lvl_on, pat_on, rdy, ms_rdy, arr_rd, pre;
    int                     err_count, checks, cyc, n, m;
    calib_modes u_dut
    (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CMD_IN(cmd), .READ_LAT_IN(read_lat),
        .STROBE_RISE_IN(strobe), .CK_SAMPLE_IN(ck_smp), .ALL_BIT_FEEDBACK_IN(all_bit),
        .DQ_OUT(dq), .DQ_OE_OUT(dq_oe), .LEVELING_OUT(lvl_on), .PATTERN_MODE_OUT(pat_on),
        .CMD_READY_OUT(rdy), .MODE_SET_READY_OUT(ms_rdy), .ARRAY_READ_OUT(arr_rd),
        .PRECHARGE_OUT(pre)
    );
    ctl_model u_ctl (.clk_in(clk), .cmd_out(cmd), .strobe_out(strobe), .ck_out(ck_smp));
    // ****************************************
    // tasks
    // ****************************************
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask : chk
    task automatic setm(input logic [2:0] b, input logic [13:0] a);
        u_ctl.issue(b, a, calib_pkg::CMD_MODE_SET);
        repeat (calib_pkg::TMOD_CYC) @(posedge clk);
    endtask : setm
    task automatic beats(input logic [7:0] pat, input int first, input int nb, input int w);
        repeat (w) @(posedge clk);
        for (int i = 0; i < nb; i++)
        begin
            @(negedge clk);
            chk("beat", dq, {8{pat[first + i]}});
            chk("beat_oe", dq_oe, 8'hFF);
            @(posedge clk);
        end
        @(negedge clk);
        chk("idle_oe", dq_oe, 8'h00);
    endtask : beats
    task automatic rd(input logic [13:0] a, input logic [7:0] pat, input int f, input int nb);
        u_ctl.issue(3'h7, a, calib_pkg::CMD_READ);
        beats(pat, f, nb, RL);
    endtask : rd
    task automatic lvl(input logic c, input logic [7:0] exp);
        u_ctl.pulse(c);
        @(posedge clk);
        @(negedge clk);
        chk("feedback", dq, exp);
    endtask : lvl
    // ****************************************
    // clock, timeout and sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        all_bit = 1'b0;
        read_lat = 5'(RL);
        {err_count, checks, cyc, n, m} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        setm(3'h1, 14'h0080);
        chk("level_on", {7'h00, lvl_on}, 8'h01);
        lvl(1'b0, 8'h00);
        lvl(1'b1, 8'h01);
        @(posedge clk);
        all_bit <= 1'b1;
        lvl(1'b1, 8'hFF);
        u_ctl.issue(3'h1, 14'h0000, calib_pkg::CMD_MODE_SET);
        repeat (20)
        begin
            @(negedge clk);
            n += int'(rdy === 1'b0);
            m += int'(ms_rdy === 1'b0);
        end
        // ready rises one cycle ahead of the first legal edge
        chk("mod_len", 8'(n), 8'(calib_pkg::TMOD_CYC - 1));
        chk("mrd_len", 8'(m), 8'(calib_pkg::TMRD_CYC - 1));
        chk("level_off", {7'h00, lvl_on}, 8'h00);
        // fixed eight, on-the-fly, fixed four; only reads while enabled
        for (int b = 0; b < 3; b++)
        begin
            setm(3'h0, 14'(b));
            setm(3'h3, 14'h0004);
            chk("pat_on", {7'h00, pat_on}, 8'h01);
            rd(14'h2FF8, calib_pkg::CALIB_PATTERN, 0, b == 0 ? 8 : 4);
            rd(14'h3FF8, calib_pkg::CALIB_PATTERN, 0, b == 2 ? 4 : 8);
            if (b == 1)
            begin
                rd(14'h2FFC, calib_pkg::CALIB_PATTERN, 4, 4);
                u_ctl.issue(3'h0, 14'h0000, calib_pkg::CMD_READ);
                repeat (2) @(posedge clk);
                u_ctl.issue(3'h0, 14'h0004, calib_pkg::CMD_READ);
                beats(calib_pkg::CALIB_PATTERN, 0, 8, RL - 4);
            end
            setm(3'h3, 14'h0000);
        end
        for (int l = 1; l < 4; l++)
        begin
            setm(3'h3, 14'(4 + l));
            rd(14'h1000, calib_pkg::RESERVED_PATTERN, 0, 4);
            setm(3'h3, 14'h0000);
        end
        u_ctl.issue(3'h0, 14'h0400, calib_pkg::CMD_READ);
        @(negedge clk);
        chk("array_ac", {6'h00, arr_rd, pre}, 8'h03);
        u_ctl.issue(3'h0, 14'h0000, calib_pkg::CMD_READ);
        @(negedge clk);
        chk("array_rd", {6'h00, arr_rd, pre}, 8'h02);
        setm(3'h3, 14'h0004);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("pat_rst", {7'h00, pat_on}, 8'h00);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
